// >>> rtl/pac_pkg.sv
// Shared constants for the parameter-access command decoder
package pac_pkg;
  // Opcodes
  localparam logic [7:0] OP_AXIS_WR = 8'h05;
  localparam logic [7:0] OP_AXIS_RD = 8'h06;
  localparam logic [7:0] OP_GLOB_WR = 8'h09;
  localparam logic [7:0] OP_GLOB_RD = 8'h0A;
  localparam logic [7:0] OP_GLOB_ST = 8'h0B;
  // Bank selectors
  localparam logic [7:0] BANK_MODULE = 8'h00;
  localparam logic [7:0] BANK_USER = 8'h02;
  localparam logic [7:0] BANK_IRQ = 8'h03;
  // Highest axis index
  localparam logic [7:0] AXIS_MAX = 8'h02;
  // Reply status codes
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VAL = 8'h04;
  // Frame layout
  localparam int FRAME_LEN = 9;
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_OP = 4'h1;
  localparam logic [3:0] IDX_TYPE = 4'h2;
  localparam logic [3:0] IDX_BANK = 4'h3;
  localparam logic [3:0] IDX_SUM = 4'h8;
  // Storage reset value
  localparam logic [31:0] PARAM_RST = 32'h0000_0000;
  // Controller states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RECV = 5'b00010,
    ST_EXEC = 5'b00100,
    ST_NVM = 5'b01000,
    ST_LOAD = 5'b10000
  } pac_state_type;
endpackage

// >>> rtl/pac_sum_acc.sv
// Running modulo-256 sum of frame bytes
`timescale 1ns/1ps
module pac_sum_acc #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_clear,
  input wire logic i_add,
  input wire logic [W-1:0] i_byte,
  // Result
  output logic [W-1:0] o_sum
);
  // Sum wraps naturally at the byte width
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sum <= '0;
    end else if (i_clear) begin
      o_sum <= '0;
    end else if (i_add) begin
      o_sum <= o_sum + i_byte;
    end
  end
endmodule

// >>> rtl/pac_cmd_decoder.sv
// Parameter-access command decoder with reply and storage hooks
// What this block does
// - Axis read opcode 6, reply 100 with value
// - Standalone axis read also loads accumulator
// - Direct axis read leaves accumulator untouched
// - Global write opcode 9 stores value, replies 100
// - Banks 0, 2, 3 only; others rejected
// - Bank zero write commits to nonvolatile store
// - Global read opcode 10 loads accumulator, replies
// - Store opcode 11 bank 2 writes nonvolatile
// - Power-on user variable reload, auto or requested
// - Axis write opcode 5 updates axis parameter
`timescale 1ns/1ps
module pac_cmd_decoder #(
  parameter int NAXIS = 3,
  parameter int NPARAM = 16,
  parameter int PW = $clog2(NPARAM)
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Command byte stream
  input wire logic i_byte_vld,
  input wire logic [7:0] i_byte,
  input wire logic i_standalone,
  // Reply
  output logic o_rply_vld,
  output logic [7:0] o_rply_status,
  output logic [7:0] o_rply_op,
  output logic [31:0] o_rply_value,
  // Accumulator
  output logic [31:0] o_accu,
  // Nonvolatile store port
  output logic o_nvm_wr,
  output logic o_nvm_rd,
  output logic [7:0] o_nvm_bank,
  output logic [PW-1:0] o_nvm_idx,
  output logic [31:0] o_nvm_wdata,
  input wire logic [31:0] i_nvm_rdata,
  input wire logic i_nvm_done,
  // Power-on reload control
  input wire logic i_auto_reload,
  input wire logic i_reload_req,
  output logic o_busy
);
  // Frame bytes captured in arrival order
  logic [7:0] frame_r [pac_pkg::FRAME_LEN];
  logic [3:0] cnt_r;
  logic [7:0] sum;
  pac_pkg::pac_state_type state_r;
  // Parameter stores, one per bank and one per axis
  logic [31:0] axis_r [NAXIS][NPARAM];
  logic [31:0] mod_r [NPARAM];
  logic [31:0] user_r [NPARAM];
  logic [31:0] irq_r [NPARAM];
  logic [PW-1:0] load_idx_r;
  logic reload_pend_r;

  // Decoded fields
  logic [7:0] op, bank;
  logic [PW-1:0] pidx;
  logic [31:0] value;
  logic sum_ok, type_ok, axis_ok, bank_ok;
  assign op = frame_r[pac_pkg::IDX_OP];
  assign bank = frame_r[pac_pkg::IDX_BANK];
  assign pidx = frame_r[pac_pkg::IDX_TYPE][PW-1:0];
  // Value bytes arrive most significant first
  assign value = {frame_r[4], frame_r[5], frame_r[6], frame_r[7]};
  assign sum_ok = (sum == frame_r[pac_pkg::IDX_SUM]);
  assign type_ok = (frame_r[pac_pkg::IDX_TYPE] < 8'(NPARAM));
  assign axis_ok = (bank <= pac_pkg::AXIS_MAX);
  assign bank_ok = (bank == pac_pkg::BANK_MODULE) ||
                   (bank == pac_pkg::BANK_USER) ||
                   (bank == pac_pkg::BANK_IRQ);

  // Byte taken into the frame; a pending reload blocks a new frame start
  logic take;
  assign take = i_byte_vld && (state_r == pac_pkg::ST_RECV ||
                (state_r == pac_pkg::ST_IDLE && !reload_pend_r));

  // Checksum over the first eight bytes; cleared in execute for next frame
  pac_sum_acc #(.W(8)) u_sum (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clear(state_r == pac_pkg::ST_EXEC),
    .i_add(take && cnt_r < pac_pkg::IDX_SUM),
    .i_byte(i_byte),
    .o_sum(sum)
  );

  // Selected global parameter
  logic [31:0] glob_rd;
  always_comb begin
    unique case (bank)
      pac_pkg::BANK_MODULE: glob_rd = mod_r[pidx];
      pac_pkg::BANK_USER: glob_rd = user_r[pidx];
      default: glob_rd = irq_r[pidx];
    endcase
  end

  // Frame capture; first byte may start a frame from idle
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 4'h0;
      for (int i = 0; i < pac_pkg::FRAME_LEN; i++) frame_r[i] <= 8'h00;
    end else if (state_r == pac_pkg::ST_EXEC) begin
      cnt_r <= 4'h0;
    end else if (take) begin
      frame_r[cnt_r] <= i_byte;
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Sequencer: idle, receive, execute, wait on store, reload
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= pac_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        pac_pkg::ST_IDLE:
          if (reload_pend_r) state_r <= pac_pkg::ST_LOAD;
          else if (i_byte_vld) state_r <= pac_pkg::ST_RECV;
        pac_pkg::ST_RECV:
          if (i_byte_vld && cnt_r == pac_pkg::IDX_SUM)
            state_r <= pac_pkg::ST_EXEC;
        pac_pkg::ST_EXEC:
          // Bank 0 writes and stores wait for the nonvolatile store
          if (o_nvm_wr) state_r <= pac_pkg::ST_NVM;
          else state_r <= pac_pkg::ST_IDLE;
        pac_pkg::ST_NVM:
          if (i_nvm_done) state_r <= pac_pkg::ST_IDLE;
        pac_pkg::ST_LOAD:
          if (i_nvm_done && load_idx_r == PW'(NPARAM - 1))
            state_r <= pac_pkg::ST_IDLE;
        default: state_r <= pac_pkg::ST_IDLE;
      endcase
    end
  end

  // Reload request: latched at release when i_auto_reload is set, or by explicit request
  logic boot_r;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_r <= 1'b1;
      reload_pend_r <= 1'b0;
    end else begin
      boot_r <= 1'b0;
      if (state_r == pac_pkg::ST_LOAD) reload_pend_r <= 1'b0;
      else if ((boot_r && i_auto_reload) || i_reload_req)
        reload_pend_r <= 1'b1;
    end
  end

  // Reload walks every user variable
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      load_idx_r <= '0;
    end else if (state_r != pac_pkg::ST_LOAD) begin
      load_idx_r <= '0;
    end else if (i_nvm_done) begin
      load_idx_r <= load_idx_r + PW'(1);
    end
  end

  // Nonvolatile port requests; write is a one-cycle strobe, read is held for the whole reload
  logic exec_ok;
  assign exec_ok = state_r == pac_pkg::ST_EXEC && sum_ok && type_ok;
  always_comb begin
    o_nvm_wr = 1'b0;
    o_nvm_bank = bank;
    o_nvm_idx = pidx;
    o_nvm_wdata = value;
    o_nvm_rd = state_r == pac_pkg::ST_LOAD;
    if (state_r == pac_pkg::ST_LOAD) begin
      o_nvm_bank = pac_pkg::BANK_USER;
      o_nvm_idx = load_idx_r;
    end else if (exec_ok && op == pac_pkg::OP_GLOB_WR &&
                 bank == pac_pkg::BANK_MODULE) begin
      o_nvm_wr = 1'b1;
    end else if (exec_ok && op == pac_pkg::OP_GLOB_ST &&
                 bank == pac_pkg::BANK_USER) begin
      o_nvm_wr = 1'b1;
      o_nvm_wdata = user_r[pidx];
    end
  end
  assign o_busy = state_r != pac_pkg::ST_IDLE;

  // Parameter writes
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int p = 0; p < NPARAM; p++) begin
        mod_r[p] <= pac_pkg::PARAM_RST;
        user_r[p] <= pac_pkg::PARAM_RST;
        irq_r[p] <= pac_pkg::PARAM_RST;
        for (int a = 0; a < NAXIS; a++) axis_r[a][p] <= pac_pkg::PARAM_RST;
      end
    end else if (state_r == pac_pkg::ST_LOAD && i_nvm_done) begin
      user_r[load_idx_r] <= i_nvm_rdata;
    end else if (exec_ok && op == pac_pkg::OP_AXIS_WR && axis_ok) begin
      axis_r[bank[1:0]][pidx] <= value;
    end else if (exec_ok && op == pac_pkg::OP_GLOB_WR && bank_ok) begin
      unique case (bank)
        pac_pkg::BANK_MODULE: mod_r[pidx] <= value;
        pac_pkg::BANK_USER: user_r[pidx] <= value;
        default: irq_r[pidx] <= value;
      endcase
    end
  end

  // Accumulator: global reads always, axis reads only standalone
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_accu <= pac_pkg::PARAM_RST;
    end else if (exec_ok && op == pac_pkg::OP_AXIS_RD && axis_ok &&
                 i_standalone) begin
      o_accu <= axis_r[bank[1:0]][pidx];
    end else if (exec_ok && op == pac_pkg::OP_GLOB_RD && bank_ok) begin
      o_accu <= glob_rd;
    end
  end

  // Reply, one-cycle strobe after execute
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rply_vld <= 1'b0;
      o_rply_status <= 8'h00;
      o_rply_op <= 8'h00;
      o_rply_value <= pac_pkg::PARAM_RST;
    end else begin
      o_rply_vld <= state_r == pac_pkg::ST_EXEC;
      if (state_r == pac_pkg::ST_EXEC) begin
        o_rply_op <= op;
        o_rply_value <= 32'h0000_0000;
        o_rply_status <= pac_pkg::ST_OK;
        if (!sum_ok) o_rply_status <= pac_pkg::ST_BAD_SUM;
        else if (!type_ok) o_rply_status <= pac_pkg::ST_BAD_TYPE;
        else begin
          unique case (op)
            pac_pkg::OP_AXIS_RD: begin
              if (!axis_ok) o_rply_status <= pac_pkg::ST_BAD_VAL;
              else o_rply_value <= axis_r[bank[1:0]][pidx];
            end
            pac_pkg::OP_AXIS_WR:
              if (!axis_ok) o_rply_status <= pac_pkg::ST_BAD_VAL;
            pac_pkg::OP_GLOB_WR:
              if (!bank_ok) o_rply_status <= pac_pkg::ST_BAD_VAL;
            pac_pkg::OP_GLOB_RD: begin
              if (!bank_ok) o_rply_status <= pac_pkg::ST_BAD_VAL;
              else o_rply_value <= glob_rd;
            end
            pac_pkg::OP_GLOB_ST:
              if (bank != pac_pkg::BANK_USER)
                o_rply_status <= pac_pkg::ST_BAD_VAL;
            default: o_rply_status <= pac_pkg::ST_BAD_CMD;
          endcase
        end
      end
    end
  end

  // Checks on the decoded behaviour
  chk_reply_after_exec: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    state_r == pac_pkg::ST_EXEC |=> o_rply_vld)
    else $error("reply missing after execute");
  chk_direct_accu_keep: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (state_r == pac_pkg::ST_EXEC && op == pac_pkg::OP_AXIS_RD &&
     !i_standalone) |=> $stable(o_accu))
    else $error("direct axis read changed accumulator");
  chk_standalone_accu: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (exec_ok && op == pac_pkg::OP_AXIS_RD && axis_ok && i_standalone)
    |=> o_accu == o_rply_value)
    else $error("standalone read did not load accumulator");
  chk_glob_rd_accu: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (exec_ok && op == pac_pkg::OP_GLOB_RD && bank_ok)
    |=> o_accu == o_rply_value && o_rply_status == pac_pkg::ST_OK)
    else $error("global read mismatch");
  chk_bank0_commit: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (exec_ok && op == pac_pkg::OP_GLOB_WR && bank == pac_pkg::BANK_MODULE)
    |-> o_nvm_wr ##1 state_r == pac_pkg::ST_NVM)
    else $error("bank zero write not committed");
  chk_store_bank2: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (state_r == pac_pkg::ST_EXEC && op == pac_pkg::OP_GLOB_ST) |->
    o_nvm_wr == (exec_ok && bank == pac_pkg::BANK_USER))
    else $error("store to wrong bank");
  chk_bad_sum_reply: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (state_r == pac_pkg::ST_EXEC && !sum_ok) |-> !o_nvm_wr
    ##1 o_rply_status == pac_pkg::ST_BAD_SUM)
    else $error("bad checksum executed");
  chk_bad_bank_rej: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (exec_ok && op == pac_pkg::OP_GLOB_WR && !bank_ok)
    |=> o_rply_status == pac_pkg::ST_BAD_VAL)
    else $error("unused bank accepted");
  chk_frame_length: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    state_r == pac_pkg::ST_EXEC |-> $past(cnt_r) == pac_pkg::IDX_SUM)
    else $error("frame length wrong");
endmodule

// >>> verification/pac_host_model.sv
// Host-side model that sends nine-byte command frames
`timescale 1ns/1ps
module pac_host_model (
  // Clock
  input wire logic i_sys_clk,
  // Byte stream toward the decoder
  output logic o_byte_vld,
  output logic [7:0] o_byte
);
  // Lines quiet at start
  initial begin
    o_byte_vld = 1'b0;
    o_byte = 8'h00;
  end
  // One frame, back to back; bad spoils the checksum
  task automatic send(input logic [7:0] op, input logic [7:0] typ,
      input logic [7:0] bank, input logic [31:0] val, input logic bad);
    logic [7:0] b [9];
    logic [7:0] sum;
    b = '{8'h01, op, typ, bank, val[31:24], val[23:16], val[15:8],
      val[7:0], 8'h00};
    sum = 8'h00;
    for (int i = 0; i < 8; i++) sum = sum + b[i];
    b[8] = bad ? ~sum : sum;
    for (int i = 0; i < 9; i++) begin
      @(posedge i_sys_clk);
      #1;
      o_byte_vld = 1'b1;
      o_byte = b[i];
    end
    @(posedge i_sys_clk);
    #1;
    o_byte_vld = 1'b0;
    // Stale byte must not look valid
    o_byte = ~o_byte;
  endtask
endmodule

// >>> verification/pac_cmd_decoder_tb.sv
// Self-checking bench for the command decoder
`timescale 1ns/1ps
module pac_cmd_decoder_tb;
  logic i_sys_clk, i_rst_b, i_byte_vld, i_standalone, o_rply_vld;
  logic [7:0] i_byte, o_rply_status, o_rply_op, o_nvm_bank, r_st;
  logic [31:0] o_rply_value, o_accu, o_nvm_wdata, r_val;
  logic [31:0] i_nvm_rdata = 32'h0000_0000;
  logic o_nvm_wr, o_nvm_rd, i_auto_reload, i_reload_req;
  logic i_nvm_done = 1'b0;
  logic o_busy;
  logic nv_busy = 1'b0;
  logic [3:0] o_nvm_idx, nv_idx;
  logic [7:0] nv_bank;
  logic [31:0] nv_data;
  int num_errors = 0, n_compared = 0, nwr = 0, nv_cnt, nvm_dly = 0;
  // Far-side host
  pac_host_model i_host (.i_sys_clk(i_sys_clk), .o_byte_vld(i_byte_vld),
    .o_byte(i_byte));
  pac_cmd_decoder i_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_byte_vld(i_byte_vld), .i_byte(i_byte), .i_standalone(i_standalone),
    .o_rply_vld(o_rply_vld), .o_rply_status(o_rply_status),
    .o_rply_op(o_rply_op), .o_rply_value(o_rply_value), .o_accu(o_accu),
    .o_nvm_wr(o_nvm_wr), .o_nvm_rd(o_nvm_rd), .o_nvm_bank(o_nvm_bank),
    .o_nvm_idx(o_nvm_idx), .o_nvm_wdata(o_nvm_wdata),
    .i_nvm_rdata(i_nvm_rdata), .i_nvm_done(i_nvm_done),
    .i_auto_reload(i_auto_reload), .i_reload_req(i_reload_req),
    .o_busy(o_busy));
  // Clock, 10 ns period
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Store responder; nvm_dly sets how slow it answers
  always @(posedge i_sys_clk) begin
    if (!nv_busy && i_nvm_done === 1'b0 && (o_nvm_wr || o_nvm_rd)) begin
      nv_busy = 1'b1;
      nv_cnt = nvm_dly;
      nv_idx = o_nvm_idx;
      if (o_nvm_rd) check(o_nvm_bank, pac_pkg::BANK_USER);
      // Fields only valid in the request cycle
      if (o_nvm_wr) begin
        nwr++;
        nv_bank = o_nvm_bank;
        nv_data = o_nvm_wdata;
      end
    end
    #1;
    i_nvm_done = 1'b0;
    i_nvm_rdata = ~i_nvm_rdata;
    if (nv_busy && nv_cnt == 0) begin
      i_nvm_done = 1'b1;
      i_nvm_rdata = 32'hA5A5_0000 | {28'h000_0000, nv_idx};
      nv_busy = 1'b0;
    end else if (nv_busy) nv_cnt--;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for idle
  task automatic wait_idle();
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 100) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (o_busy !== 1'b0) num_errors++;
  endtask
  // One frame, reply captured
  task automatic cmd(input logic [7:0] op, input logic [7:0] typ,
      input logic [7:0] bank, input logic [31:0] val, input logic bad,
      input logic sa);
    int n;
    i_standalone = sa;
    i_host.send(op, typ, bank, val, bad);
    n = 0;
    while (o_rply_vld !== 1'b1 && n < 60) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (o_rply_vld !== 1'b1) num_errors++;
    r_st = o_rply_status;
    r_val = o_rply_value;
    check(o_rply_op, op);
    wait_idle();
  endtask
  // Reset, held 3 cycles
  task automatic do_reset(input logic auto_rl);
    i_rst_b = 1'b0;
    i_auto_reload = auto_rl;
    repeat (3) @(posedge i_sys_clk);
    #1;
    i_rst_b = 1'b1;
  endtask
  // Axis write then direct and standalone reads
  task automatic t_axis();
    cmd(pac_pkg::OP_AXIS_WR, 8'h04, 8'h01, 32'h1234_5678, 0, 0);
    check(r_st, pac_pkg::ST_OK);
    cmd(pac_pkg::OP_AXIS_RD, 8'h04, 8'h01, 32'h0000_0000, 0, 0);
    check(r_st, pac_pkg::ST_OK);
    check(r_val, 32'h1234_5678);
    check(o_accu, 32'h0000_0000);
    cmd(pac_pkg::OP_AXIS_RD, 8'h04, 8'h01, 32'h0000_0000, 0, 1);
    check(o_accu, 32'h1234_5678);
    cmd(pac_pkg::OP_AXIS_RD, 8'h04, 8'h03, 32'h0000_0000, 0, 0);
    check(r_st, pac_pkg::ST_BAD_VAL);
  endtask
  // Same type in all three banks; only bank zero commits
  task automatic t_global();
    logic [7:0] bk [3];
    int w;
    bk = '{8'h00, 8'h02, 8'h03};
    for (int i = 0; i < 3; i++) begin
      w = nwr;
      cmd(pac_pkg::OP_GLOB_WR, 8'h05, bk[i], 32'hC0DE_0000 + i, 0, 0);
      check(r_st, pac_pkg::ST_OK);
      check(nwr - w, (i == 0) ? 1 : 0);
      if (i == 0) check(nv_data, 32'hC0DE_0000);
    end
    for (int i = 0; i < 3; i++) begin
      cmd(pac_pkg::OP_GLOB_RD, 8'h05, bk[i], 32'hFFFF_FFFF, 0, 0);
      check(r_val, 32'hC0DE_0000 + i);
      check(o_accu, 32'hC0DE_0000 + i);
    end
    cmd(pac_pkg::OP_GLOB_WR, 8'h05, 8'h01, 32'h0000_0001, 0, 0);
    check(r_st, pac_pkg::ST_BAD_VAL);
  endtask
  // Store to nonvolatile with a slow store, then wrong bank
  task automatic t_store();
    int w;
    nvm_dly = 5;
    cmd(pac_pkg::OP_GLOB_WR, 8'h0F, 8'h02, 32'h8765_4321, 0, 0);
    w = nwr;
    cmd(pac_pkg::OP_GLOB_ST, 8'h0F, 8'h02, 32'h0000_0000, 0, 0);
    check(r_st, pac_pkg::ST_OK);
    check(nwr - w, 1);
    check({nv_bank, 20'h0_0000, nv_idx}, 32'h0200_000F);
    check(nv_data, 32'h8765_4321);
    cmd(pac_pkg::OP_GLOB_ST, 8'h0F, 8'h00, 32'h0000_0000, 0, 0);
    check(r_st, pac_pkg::ST_BAD_VAL);
    nvm_dly = 0;
  endtask
  // Bad checksum has no effect; bad opcode and type refused
  task automatic t_errs();
    cmd(pac_pkg::OP_GLOB_WR, 8'h01, 8'h02, 32'hDEAD_BEEF, 1, 0);
    check(r_st, pac_pkg::ST_BAD_SUM);
    cmd(pac_pkg::OP_GLOB_RD, 8'h01, 8'h02, 32'h0000_0000, 0, 0);
    check(r_val, 32'h0000_0000);
    cmd(8'h04, 8'h00, 8'h00, 32'h0000_0000, 0, 0);
    check(r_st, pac_pkg::ST_BAD_CMD);
    cmd(pac_pkg::OP_AXIS_RD, 8'h10, 8'h00, 32'h0000_0000, 0, 0);
    check(r_st, pac_pkg::ST_BAD_TYPE);
  endtask
  // Reload on request, then automatically after reset
  task automatic t_reload();
    @(posedge i_sys_clk);
    #1;
    i_reload_req = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_reload_req = 1'b0;
    @(posedge i_sys_clk);
    #1;
    check(o_busy, 1'b1);
    wait_idle();
    cmd(pac_pkg::OP_GLOB_RD, 8'h0F, 8'h02, 32'h0000_0000, 0, 0);
    check(r_val, 32'hA5A5_000F);
    do_reset(1'b1);
    repeat (3) @(posedge i_sys_clk);
    #1;
    check(o_busy, 1'b1);
    wait_idle();
    cmd(pac_pkg::OP_GLOB_RD, 8'h07, 8'h02, 32'h0000_0000, 0, 0);
    check(r_val, 32'hA5A5_0007);
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    i_standalone = 1'b0;
    i_reload_req = 1'b0;
    do_reset(1'b0);
    t_axis();
    t_global();
    t_store();
    t_errs();
    t_reload();
    print_verdict();
  end
  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
endmodule
